// [hdl/spif_regs.svh]
`ifndef SPIF_REGS_SVH
`define SPIF_REGS_SVH
// Operation
// R1 - The prescale divisor is an 8-bit read/write field that software sets to an even 2..254.
// R2 - Bit 0 of the prescale divisor always reads zero, so odd divisors never take effect.
// R3 - In slave mode software sets the serial clock rate to 0x00 and the divisor to 0x02.
// R4 - The transmit enable at bit 3 passes the transmit level condition only while set.
// R5 - The receive enable at bit 2 passes the receive level condition only while set.
// R6 - The time-out enable at bit 1 passes the receive time-out condition only while set.
// R7 - The overrun enable at bit 0 passes the receive overrun condition only while set.
// R8 - The raw transmit flag at bit 3 shows the transmit level condition and reads 1 at reset.
// R9 - The raw receive flag at bit 2 shows the receive level condition and is 0 at reset.
// R10 - The raw time-out flag at bit 1 reports a receive time-out and is 0 at reset.
// R11 - The raw overrun flag at bit 0 reports a receive overrun and is 0 at reset.
// R12 - Each masked bit is its raw flag ANDed with its enable and is readable on its own.
// R13 - Transmit level means four or fewer entries held; receive level means four or more.
// R14 - In master mode the serial clock is the system clock over divisor times one plus rate.
// R15 - Writing 1 to a clear bit clears the time-out or overrun flag; writing 0 does nothing.
// R16 - The interrupt output is high exactly while any masked bit is 1; the code registers irq, so it follows one cycle later.
// R17 - Software writes zeros to all unused upper bits of these registers.

// =====================================
// register offsets
`define SPIF_OFS_PRESCALE 8'h00
`define SPIF_OFS_IRQ_EN   8'h04
`define SPIF_OFS_RAW      8'h08
`define SPIF_OFS_MASKED   8'h0C
`define SPIF_OFS_CLEAR    8'h10
`define SPIF_OFS_CTRL     8'h14

// =====================================
// field positions
`define SPIF_BIT_TX       3
`define SPIF_BIT_RX       2
`define SPIF_BIT_TO       1
`define SPIF_BIT_OVR      0
`define SPIF_CTRL_RATE_MSB 7
`define SPIF_CTRL_SLAVE   8
`define SPIF_CTRL_RUN     9

// =====================================
// reset values and levels
`define SPIF_RST_HALF     7'h00
`define SPIF_RST_IRQ_EN   4'h0
`define SPIF_RST_RATE     8'h00
`define SPIF_TX_LEVEL_MAX 4'h4
`define SPIF_RX_LEVEL_MIN 4'h4
`define SPIF_HALF_MIN     7'h01
`endif

// [hdl/spif_pkg.sv]
package spif_pkg;
  // gray along idle -> low -> high -> low
  typedef enum logic [1:0] {
    SPIF_DIV_IDLE = 2'b00,
    SPIF_DIV_LOW  = 2'b01,
    SPIF_DIV_HIGH = 2'b11
  } spif_div_state_t;
  typedef logic [3:0] spif_flags_t;
endpackage

// [hdl/spif_flag_if.sv]
`timescale 1ns/10ps
interface spif_flag_if;
  logic [3:0]          txCount;
  logic [3:0]          rxCount;
  logic                toEvt;
  logic                ovrEvt;
  logic                toClr;
  logic                ovrClr;
  spif_pkg::spif_flags_t raw;
  modport core  (output txCount, rxCount, toEvt, ovrEvt, toClr, ovrClr, input raw);
  modport flags (input txCount, rxCount, toEvt, ovrEvt, toClr, ovrClr, output raw);
endinterface

// [hdl/spif_raw_flags.sv]
`timescale 1ns/10ps
`include "spif_regs.svh"
module spif_raw_flags (
  input wire logic   clk,
  input wire logic   rst_b,
  input wire logic   ce,
  spif_flag_if.flags f
);
  logic txLevel;
  logic rxLevel;
  logic toFlag;
  logic ovrFlag;

  // each flag has its own flop so no two processes share one vector
  assign f.raw[`SPIF_BIT_TX]  = txLevel;
  assign f.raw[`SPIF_BIT_RX]  = rxLevel;
  assign f.raw[`SPIF_BIT_TO]  = toFlag;
  assign f.raw[`SPIF_BIT_OVR] = ovrFlag;

  // =====================================
  // level flags follow the fifo fill counts
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txLevel <= 1'b1;
      rxLevel <= 1'b0;
    end else if (ce) begin
      txLevel <= (f.txCount <= `SPIF_TX_LEVEL_MAX); // R8 R13
      rxLevel <= (f.rxCount >= `SPIF_RX_LEVEL_MIN); // R9 R13
    end
  end

  // =====================================
  // sticky event flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      toFlag  <= 1'b0;
      ovrFlag <= 1'b0;
    end else if (ce) begin
      toFlag  <= f.toEvt | (toFlag & ~f.toClr); // R10 R15
      ovrFlag <= f.ovrEvt | (ovrFlag & ~f.ovrClr); // R11 R15
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ovr_clear;
    ce && f.ovrClr && !f.ovrEvt;
  endsequence
  a_tx_level: assert property (ce |=> f.raw[3] == ($past(f.txCount) <= 4'h4)) // R8
    else $error("tx level flag wrong");
  a_rx_level: assert property (ce |=> f.raw[2] == ($past(f.rxCount) >= 4'h4)) // R9
    else $error("rx level flag wrong");
  a_to_set_wins: assert property (ce && f.toEvt |=> f.raw[1]) // R10
    else $error("time-out event lost");
  a_ovr_set: assert property (ce && f.ovrEvt |=> f.raw[0]) // R11
    else $error("overrun event lost");
  a_ovr_clear: assert property (s_ovr_clear |=> !f.raw[0]) // R15
    else $error("overrun flag not cleared");
  a_ovr_hold: assert property (ce && f.raw[0] && !f.ovrClr |=> f.raw[0]) // R15
    else $error("overrun flag dropped");
endmodule

// [hdl/spif_clk_div.sv]
`timescale 1ns/10ps
`include "spif_regs.svh"
module spif_clk_div (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [6:0] halfDiv,
  input  wire logic [7:0] rate,
  output logic            serialClk
);
  spif_pkg::spif_div_state_t state;
  spif_pkg::spif_div_state_t next_state;
  logic [6:0]                preCnt;
  logic [7:0]                rateCnt;
  logic [6:0]                halfEff;
  logic                      preWrap;
  logic                      halfWrap;

  // a divisor written as zero would stall the clock, so run it as two
  assign halfEff  = (halfDiv == 7'h00) ? `SPIF_HALF_MIN : halfDiv;
  // >= so a divisor or rate lowered mid-run wraps at once, not after a full roll-over
  assign preWrap  = (state != spif_pkg::SPIF_DIV_IDLE) && (preCnt >= halfEff - 7'h01);
  assign halfWrap = preWrap && (rateCnt >= rate); // R14

  always_comb begin
    next_state = state;
    case (state)
      spif_pkg::SPIF_DIV_IDLE: if (run) next_state = spif_pkg::SPIF_DIV_LOW;
      spif_pkg::SPIF_DIV_LOW:  if (!run) next_state = spif_pkg::SPIF_DIV_IDLE;
        else if (halfWrap) next_state = spif_pkg::SPIF_DIV_HIGH;
      spif_pkg::SPIF_DIV_HIGH: if (!run) next_state = spif_pkg::SPIF_DIV_IDLE;
        else if (halfWrap) next_state = spif_pkg::SPIF_DIV_LOW;
      default: next_state = spif_pkg::SPIF_DIV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state     <= spif_pkg::SPIF_DIV_IDLE;
      serialClk <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      serialClk <= (next_state == spif_pkg::SPIF_DIV_HIGH); // R14
    end
  end

  // first counter divides by half the divisor, second by rate plus one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      preCnt  <= 7'h00;
      rateCnt <= 8'h00;
    end else if (ce) begin
      if (state == spif_pkg::SPIF_DIV_IDLE || preWrap) preCnt <= 7'h00;
      else preCnt <= preCnt + 7'h01;
      if (state == spif_pkg::SPIF_DIV_IDLE || halfWrap) rateCnt <= 8'h00;
      else if (preWrap) rateCnt <= rateCnt + 8'h01;
    end
  end

  // one cycle of overshoot is allowed right after the divisor is rewritten
  a_pre_bound: assert property (@(posedge clk) disable iff (!rst_b) // R14
    $past(ce) && $stable(halfEff) |-> preCnt < halfEff)
    else $error("prescale counter out of range");
endmodule

// [hdl/spif_prescale_irq.sv]
`timescale 1ns/10ps
`include "spif_regs.svh"
module spif_prescale_irq (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        we,
  input  wire logic        re,
  output logic      [31:0] rdata,
  input  wire logic [3:0]  txCount,
  input  wire logic [3:0]  rxCount,
  input  wire logic        rxTimeoutEvt,
  input  wire logic        rxOverrunEvt,
  output logic             serialClk,
  output logic             slaveMode,
  output logic             irq
);
  // =====================================
  // state
  logic [6:0]            prescaleHalf;
  logic [3:0]            irqEnable;
  logic [7:0]            serialClockRate;
  logic                  slaveModeSelect;
  logic                  portEnable;
  spif_pkg::spif_flags_t masked;
  spif_pkg::spif_flags_t raw;
  logic [31:0]           next_rdata;
  logic                  wrPrescale;
  logic                  wrIrqEn;
  logic                  wrClear;
  logic                  wrCtrl;
  logic                  divRun;

  spif_flag_if flagBus ();

  // =====================================
  // write decode
  assign wrPrescale = we && (addr == `SPIF_OFS_PRESCALE);
  assign wrIrqEn    = we && (addr == `SPIF_OFS_IRQ_EN);
  assign wrClear    = we && (addr == `SPIF_OFS_CLEAR);
  assign wrCtrl     = we && (addr == `SPIF_OFS_CTRL);

  // =====================================
  // prescale divisor
  // only bits 7..1 are held; bit 0 has no storage and cannot make odd divisors
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prescaleHalf <= `SPIF_RST_HALF;
    end else if (ce && wrPrescale) begin
      prescaleHalf <= wdata[7:1]; // R1 R2
    end
  end

  // =====================================
  // interrupt enables
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqEnable <= `SPIF_RST_IRQ_EN;
    end else if (ce && wrIrqEn) begin
      irqEnable <= wdata[3:0];
    end
  end

  // =====================================
  // control: rate, slave select, run
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      serialClockRate <= `SPIF_RST_RATE;
      slaveModeSelect <= 1'b0;
      portEnable      <= 1'b0;
    end else if (ce && wrCtrl) begin
      serialClockRate <= wdata[`SPIF_CTRL_RATE_MSB:0];
      slaveModeSelect <= wdata[`SPIF_CTRL_SLAVE];
      portEnable      <= wdata[`SPIF_CTRL_RUN];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slaveMode <= 1'b0;
    end else if (ce) begin
      slaveMode <= slaveModeSelect;
    end
  end

  // =====================================
  // raw flags
  // fifo counts and events come from logic on this clock, so no synchroniser
  assign flagBus.txCount = txCount;
  assign flagBus.rxCount = rxCount;
  assign flagBus.toEvt   = rxTimeoutEvt;
  assign flagBus.ovrEvt  = rxOverrunEvt;
  assign flagBus.toClr   = wrClear && wdata[`SPIF_BIT_TO]; // R15
  assign flagBus.ovrClr  = wrClear && wdata[`SPIF_BIT_OVR]; // R15
  assign raw             = flagBus.raw;

  spif_raw_flags u_flags (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .f     (flagBus.flags)
  );

  // =====================================
  // masking and interrupt output
  assign masked[`SPIF_BIT_TX]  = raw[`SPIF_BIT_TX]  & irqEnable[`SPIF_BIT_TX]; // R4 R12
  assign masked[`SPIF_BIT_RX]  = raw[`SPIF_BIT_RX]  & irqEnable[`SPIF_BIT_RX]; // R5 R12
  assign masked[`SPIF_BIT_TO]  = raw[`SPIF_BIT_TO]  & irqEnable[`SPIF_BIT_TO]; // R6 R12
  assign masked[`SPIF_BIT_OVR] = raw[`SPIF_BIT_OVR] & irqEnable[`SPIF_BIT_OVR]; // R7 R12

  // registered so the pin is glitch free; costs one cycle of latency
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |masked; // R16
    end
  end

  // =====================================
  // serial clock generation
  // a slave takes its clock from the far end, so the divider stands still
  assign divRun = portEnable && !slaveModeSelect;

  spif_clk_div u_div (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .run       (divRun),
    .halfDiv   (prescaleHalf),
    .rate      (serialClockRate),
    .serialClk (serialClk)
  );

  // =====================================
  // read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `SPIF_OFS_PRESCALE: begin
        next_rdata[7:0] = {prescaleHalf, 1'b0}; // R2
      end
      `SPIF_OFS_IRQ_EN: begin
        next_rdata[3:0] = irqEnable;
      end
      `SPIF_OFS_RAW: begin
        next_rdata[3:0] = raw; // R8 R9 R10 R11
      end
      `SPIF_OFS_MASKED: begin
        next_rdata[3:0] = masked; // R12
      end
      `SPIF_OFS_CTRL: begin
        next_rdata[`SPIF_CTRL_RATE_MSB:0] = serialClockRate;
        next_rdata[`SPIF_CTRL_SLAVE]      = slaveModeSelect;
        next_rdata[`SPIF_CTRL_RUN]        = portEnable;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= re ? next_rdata : 32'h0000_0000;
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr_prescale;
    ce && we && (addr == 8'h00);
  endsequence

  sequence s_rd_prescale;
    ce && re && (addr == 8'h00);
  endsequence

  a_prescale_back: assert property ( // R2
    s_wr_prescale ##1 s_rd_prescale |=>
      rdata[7:0] == {$past(wdata[7:1], 2), 1'b0})
    else $error("prescale readback wrong");

  a_masked_read: assert property ( // R12
    ce && re && (addr == 8'h0C) |=>
      rdata[3:0] == $past(raw & irqEnable))
    else $error("masked status readback wrong");

  a_raw_read: assert property ( // R11
    ce && re && (addr == 8'h08) |=>
      rdata == {28'h0000000, $past(raw)})
    else $error("raw status readback wrong");

  a_irq_level: assert property ( // R16
    ce |=> irq == $past(|(raw & irqEnable)))
    else $error("interrupt level wrong");

  a_enable_gate: assert property ( // R4
    ce && irqEnable == 4'h0 |=> !irq)
    else $error("disabled source reached interrupt");

  a_tx_to_irq: assert property ( // R4
    ce && irqEnable[3] && txCount <= 4'h4 ##1 ce && irqEnable[3] |=> irq)
    else $error("enabled tx level did not interrupt");

  a_slave_still: assert property ( // R14
    ce && slaveModeSelect |=> !serialClk)
    else $error("serial clock runs in slave mode");

  a_rdata_idle: assert property (
    ce && !re |=> rdata == 32'h0000_0000)
    else $error("read data outside read answer");
endmodule

// [sim/spif_fifo_peer.sv]
`timescale 1ns/10ps
// =====================================
// stand-in for the fifo side: fill levels and detector pulses
module spif_fifo_peer (
  input  wire logic       clk,
  output logic      [3:0] txCount,
  output logic      [3:0] rxCount,
  output logic            toEvt,
  output logic            ovrEvt
);
  initial begin
    txCount = 4'h0;
    rxCount = 4'h0;
    toEvt = 1'b0;
    ovrEvt = 1'b0;
  end
  // levels clipped to the eight-entry depth, a real fifo cannot report more
  task automatic setLevels(input int tx, input int rx);
    @(posedge clk);
    txCount <= 4'((tx > 8) ? 8 : tx);
    rxCount <= 4'((rx > 8) ? 8 : rx);
  endtask
  // one-cycle detector pulse, ovr picks overrun, else time-out
  task automatic pulse(input bit ovr);
    @(posedge clk);
    if (ovr) ovrEvt <= 1'b1;
    else toEvt <= 1'b1;
    @(posedge clk);
    ovrEvt <= 1'b0;
    toEvt <= 1'b0;
  endtask
endmodule

// [sim/ssp_prescale_and_irq_flags_tb_top.sv]
`timescale 1ns/10ps
`include "spif_regs.svh"
module ssp_prescale_and_irq_flags_tb_top;
  logic        clk;
  logic        rst_b;
  logic        ce;
  logic        we;
  logic        re;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  txCount;
  logic [3:0]  rxCount;
  logic        toEvt;
  logic        ovrEvt;
  logic        serialClk;
  logic        slaveMode;
  logic        irq;
  int          badCount;
  int          checks;
  int          cycles;
  int          mTx, mRx, mTo, mOvr, mEn, k, g, c;
  logic [7:0]  v;
  logic [3:0]  enTab [7] = '{4'hF, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5};

  spif_prescale_irq DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .txCount(txCount), .rxCount(rxCount),
    .rxTimeoutEvt(toEvt), .rxOverrunEvt(ovrEvt), .serialClk(serialClk),
    .slaveMode(slaveMode), .irq(irq));
  spif_fifo_peer PEER (.clk(clk), .txCount(txCount), .rxCount(rxCount), .toEvt(toEvt),
    .ovrEvt(ovrEvt));

  always #10 clk = ~clk;

  // =====================================
  // reference model and bus tasks
  function automatic logic [31:0] expRaw();
    return {28'h0, mTx <= 4, mRx >= 4, mTo[0], mOvr[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // write strobe followed straight by a read strobe, no idle cycle between
  task automatic wrRd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // gap between the first two rising edges, and how many rises in the window
  task automatic measure(output int gap, output int cnt);
    int i, last, t0;
    last = 1;
    cnt = 0;
    gap = 0;
    t0 = 0;
    for (i = 0; i < 96; i++) begin
      @(posedge clk);
      #1;
      if (serialClk === 1'b1 && last == 0) begin
        if (cnt == 1) gap = i - t0;
        t0 = i;
        cnt++;
      end
      last = (serialClk === 1'b1);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      results();
    end
  end

  // =====================================
  // test sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    badCount = 0;
    checks = 0;
    cycles = 0;
    mTx = 0;
    mRx = 0;
    mTo = 0;
    mOvr = 0;
    mEn = 0;
    void'($urandom(32'h6A305D50));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(`SPIF_OFS_PRESCALE, 32'h0);
    rd(`SPIF_OFS_IRQ_EN, 32'h0);
    rd(`SPIF_OFS_RAW, expRaw());
    rd(`SPIF_OFS_MASKED, 32'h0);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    chk({29'h0, irq, slaveMode, serialClk}, 32'h0);
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'hFF : 8'($urandom_range(2, 254));
      wrRd(`SPIF_OFS_PRESCALE, {24'h0, v}, {24'h0, v & 8'hFE});
    end
    @(posedge clk);
    ce <= 1'b0;
    wr(`SPIF_OFS_PRESCALE, 32'h10);
    ce <= 1'b1;
    rd(`SPIF_OFS_PRESCALE, {24'h0, v & 8'hFE});
    $display("test prescale done");
    for (k = 0; k < 8; k++) begin
      mTx = k + 1;
      mRx = 8 - k;
      PEER.setLevels(mTx, mRx);
      rd(`SPIF_OFS_RAW, expRaw());
    end
    $display("test levels done");
    mTx = 0;
    mRx = 8;
    PEER.setLevels(mTx, mRx);
    PEER.pulse(1'b0);
    PEER.pulse(1'b1);
    mTo = 1;
    mOvr = 1;
    rd(`SPIF_OFS_RAW, expRaw());
    for (k = 0; k < 7; k++) begin
      mEn = enTab[k];
      wr(`SPIF_OFS_IRQ_EN, mEn);
      rd(`SPIF_OFS_IRQ_EN, mEn);
      rd(`SPIF_OFS_MASKED, expRaw() & mEn);
      chk({31'h0, irq}, {31'h0, |(expRaw() & mEn)});
    end
    $display("test mask done");
    mEn = 3;
    wr(`SPIF_OFS_IRQ_EN, mEn);
    wr(`SPIF_OFS_CLEAR, 32'h0);
    rd(`SPIF_OFS_RAW, expRaw());
    wr(`SPIF_OFS_CLEAR, 32'h2);
    mTo = 0;
    rd(`SPIF_OFS_RAW, expRaw());
    chk({31'h0, irq}, 32'h1);
    wr(`SPIF_OFS_CLEAR, 32'h1);
    mOvr = 0;
    rd(`SPIF_OFS_RAW, expRaw());
    chk({31'h0, irq}, 32'h0);
    // event and clear strobe at the same edge: the event must win
    fork
      PEER.pulse(1'b0);
      wr(`SPIF_OFS_CLEAR, 32'h2);
    join
    mTo = 1;
    rd(`SPIF_OFS_RAW, expRaw());
    chk({31'h0, irq}, 32'h1);
    wr(`SPIF_OFS_CLEAR, 32'h2);
    mTo = 0;
    wr(`SPIF_OFS_RAW, 32'h0);
    rd(`SPIF_OFS_RAW, expRaw());
    rd(`SPIF_OFS_CLEAR, 32'h0);
    rd(8'h20, 32'h0);
    $display("test clear done");
    for (k = 0; k < 3; k++) begin
      wr(`SPIF_OFS_PRESCALE, 2 * (k + 1));
      wr(`SPIF_OFS_CTRL, 32'h200 | k);
      measure(g, c);
      chk(g, 2 * (k + 1) * (k + 1));
    end
    wr(`SPIF_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, serialClk}, 32'h0);
    wr(`SPIF_OFS_PRESCALE, 32'h2);
    wr(`SPIF_OFS_CTRL, 32'h300);
    measure(g, c);
    chk(c, 0);
    chk({31'h0, slaveMode}, 32'h1);
    $display("test serial clock done");
    PEER.pulse(1'b1);
    mOvr = 1;
    rd(`SPIF_OFS_RAW, expRaw());
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    mOvr = 0;
    rd(`SPIF_OFS_RAW, expRaw());
    rd(`SPIF_OFS_CTRL, 32'h0);
    chk({29'h0, irq, slaveMode, serialClk}, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule
